// [rtl/gput_timer.v]
// Up/down timer with capture, reached over a classic Wishbone slave
`timescale 1ns/1ps
`include "gput_map.vh"

module gput_timer (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [31:0] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Source clock ticks, one clk_i cycle wide
   input  wire        hclk_tick_i,
   input  wire        low_freq_osc_tick_i,
   input  wire        hfosc_tick_i,
   // Capture event sources, one clk_i cycle wide
   input  wire [15:0] event_i
);

   // Bus decode
   wire        req;
   wire        wr_stb;
   wire        rd_stb;
   wire        hit_reload;
   wire        hit_count;
   wire        hit_control;
   wire        hit_clear;
   wire        hit_capture;
   wire        hit_status;
   wire        hit_t1_status;
   wire [15:0] wr_mask;

   // Software-side registers
   reg  [15:0] control_reg;
   reg  [15:0] reload_value_reg;
   reg  [15:0] reload_new_reg;
   reg         reload_pend_reg;
   reg         busy_reg;
   reg  [1:0]  xfer_cnt_reg;
   reg         clear_sync_pending_reg;
   reg  [1:0]  clr_cnt_reg;

   // Timer-side state
   reg  [15:0] ctrl_act_reg;
   reg  [15:0] count_reg;
   reg  [15:0] count_next;
   reg  [14:0] pre_cnt_reg;
   reg  [14:0] pre_div;
   reg         src_tick;
   reg         en_d_reg;
   reg         timeout_flag_reg;
   reg         capture_pending_reg;
   reg  [15:0] captured_count_reg;
   reg  [15:0] cnt_meta_reg;
   reg  [15:0] cnt_sync_reg;

   wire        tmr_en;
   wire        periodic_select;
   wire        count_up;
   wire        start_evt;
   wire        tick;
   wire        at_end;
   wire        timeout_evt;
   wire        clr_timeout_flag_wr;
   wire        clr_cap_wr;
   wire        clr_apply;
   wire        cap_evt;
   wire [15:0] free_start;
   wire [15:0] status_word;

   // Only the low two lanes exist; upper lanes are ignored
   assign req           = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_stb        = req & wb_we_i;
   assign rd_stb        = req & ~wb_we_i;
   assign hit_reload    = (wb_adr_i == `GPUT_ADR_RELOAD);
   assign hit_count     = (wb_adr_i == `GPUT_ADR_COUNT);
   assign hit_control   = (wb_adr_i == `GPUT_ADR_CONTROL);
   assign hit_clear     = (wb_adr_i == `GPUT_ADR_CLEAR);
   assign hit_capture   = (wb_adr_i == `GPUT_ADR_CAPTURE);
   assign hit_status    = (wb_adr_i == `GPUT_ADR_STATUS);
   assign hit_t1_status = (wb_adr_i == `GPUT_ADR_T1_STATUS);
   assign wr_mask       = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Single-cycle answer; unmapped addresses are acked and read as zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_stb) begin
         if (hit_reload) begin
            wb_dat_o <= {16'h0000, reload_pend_reg ? reload_new_reg : reload_value_reg};
         end else if (hit_count) begin
            wb_dat_o <= {16'h0000, cnt_sync_reg};
         end else if (hit_control) begin
            wb_dat_o <= {16'h0000, control_reg};
         end else if (hit_capture) begin
            wb_dat_o <= {16'h0000, captured_count_reg};
         end else if (hit_status) begin
            wb_dat_o <= {16'h0000, status_word};
         end else if (hit_t1_status) begin
            wb_dat_o <= {16'h0000, `GPUT_RST_WORD};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // Timer 1 itself is not built here, so its status word reads as zero
   assign status_word = {8'h00, clear_sync_pending_reg, busy_reg, 4'h0,
                         capture_pending_reg, timeout_flag_reg};

   // Control write: software copy now, timer copy after the crossing delay
   always @(posedge clk_i) begin
      if (rst_i) begin
         control_reg  <= `GPUT_RST_CONTROL;
         ctrl_act_reg <= `GPUT_RST_CONTROL;
         busy_reg     <= 1'b0;
         xfer_cnt_reg <= 2'd0;
      end else if (wr_stb && hit_control && !busy_reg) begin
         // Writes while busy are dropped; software must wait for busy low
         control_reg  <= ((control_reg & ~wr_mask) | (wb_dat_i[15:0] & wr_mask))
                         & `GPUT_CTL_MASK;
         busy_reg     <= 1'b1;
         xfer_cnt_reg <= `GPUT_XFER_CYC;
      end else if (busy_reg) begin
         if (xfer_cnt_reg == 2'd1) begin
            ctrl_act_reg <= control_reg;
            busy_reg     <= 1'b0;
         end
         xfer_cnt_reg <= xfer_cnt_reg - 2'd1;
      end
   end

   // Load register; a write during a timeout waits one cycle
   // Readback shows the newest write while it still waits
   always @(posedge clk_i) begin
      if (rst_i) begin
         reload_value_reg <= `GPUT_RST_WORD;
         reload_new_reg   <= `GPUT_RST_WORD;
         reload_pend_reg  <= 1'b0;
      end else begin
         if (wr_stb && hit_reload) begin
            reload_new_reg  <= ((reload_pend_reg ? reload_new_reg : reload_value_reg) & ~wr_mask)
                               | (wb_dat_i[15:0] & wr_mask);
            reload_pend_reg <= 1'b1;
         end else if (reload_pend_reg && !timeout_evt) begin
            reload_value_reg <= reload_new_reg;
            reload_pend_reg  <= 1'b0;
         end
      end
   end

   // Clear register strobes
   // Capture clear acts at once; only the timeout clear crosses
   assign clr_timeout_flag_wr = wr_stb & hit_clear & wb_sel_i[0] & wb_dat_i[`GPUT_CLR_TIMEOUT_FLAG];
   assign clr_cap_wr   = wr_stb & hit_clear & wb_sel_i[0] & wb_dat_i[`GPUT_CLR_CAP];
   assign clr_apply    = clear_sync_pending_reg & (clr_cnt_reg == 2'd1);

   // Timeout clear crosses with a fixed delay
   always @(posedge clk_i) begin
      if (rst_i) begin
         clear_sync_pending_reg <= 1'b0;
         clr_cnt_reg            <= 2'd0;
      end else if (clr_timeout_flag_wr) begin
         clear_sync_pending_reg <= 1'b1;
         clr_cnt_reg            <= `GPUT_XFER_CYC;
      end else if (clear_sync_pending_reg) begin
         if (clr_cnt_reg == 2'd1) begin
            clear_sync_pending_reg <= 1'b0;
         end
         clr_cnt_reg <= clr_cnt_reg - 2'd1;
      end
   end

   // Timer controls as seen by the counter
   assign tmr_en          = ctrl_act_reg[`GPUT_CTL_ENABLE];
   assign periodic_select = ctrl_act_reg[`GPUT_CTL_PERIODIC];
   assign count_up        = ctrl_act_reg[`GPUT_CTL_UP];
   assign start_evt       = tmr_en & ~en_d_reg;
   assign free_start      = count_up ? `GPUT_CNT_ZERO : `GPUT_CNT_FULL;

   // Source select; other sources arrive as ticks because there is one clock
   always @* begin
      case (ctrl_act_reg[`GPUT_CTL_SRC_HI:`GPUT_CTL_SRC_LO])
         `GPUT_SRC_PCLK:  src_tick = 1'b1;
         `GPUT_SRC_HCLK:  src_tick = hclk_tick_i;
         `GPUT_SRC_LOW_FREQ_OSC: src_tick = low_freq_osc_tick_i;
         `GPUT_SRC_HFOSC: src_tick = hfosc_tick_i;
         default:         src_tick = 1'b0;
      endcase
   end

   always @* begin
      case (ctrl_act_reg[`GPUT_CTL_PRE_HI:`GPUT_CTL_PRE_LO])
         2'b00:   pre_div = ctrl_act_reg[`GPUT_CTL_SRC_HI] ? `GPUT_DIV_1 : `GPUT_DIV_4;
         2'b01:   pre_div = `GPUT_DIV_16;
         2'b10:   pre_div = `GPUT_DIV_256;
         2'b11:   pre_div = `GPUT_DIV_32768;
         default: pre_div = `GPUT_DIV_1;
      endcase
   end

   // No tick in the start cycle, so the first period is whole
   assign tick        = tmr_en & ~start_evt & src_tick & (pre_cnt_reg >= pre_div);
   assign at_end      = count_up ? (count_reg == `GPUT_CNT_FULL)
                                 : (count_reg == `GPUT_CNT_ZERO);
   assign timeout_evt = tick & at_end;

   // Prescaler
   // Restarts on enable and on each tick, so no period is short
   always @(posedge clk_i) begin
      if (rst_i) begin
         pre_cnt_reg <= 15'h0000;
      end else if (!tmr_en || start_evt || tick) begin
         pre_cnt_reg <= 15'h0000;
      end else if (src_tick) begin
         pre_cnt_reg <= pre_cnt_reg + 15'h0001;
      end
   end

   // Counter next value
   // Clear-driven reload outranks timeout; both land on the load value
   always @* begin
      count_next = count_reg;
      if (!tmr_en) begin
         count_next = `GPUT_CNT_ZERO;
      end else if (start_evt) begin
         count_next = periodic_select ? reload_value_reg : free_start;
      end else if (periodic_select && ctrl_act_reg[`GPUT_CTL_RST_CLR] && clr_apply) begin
         count_next = reload_value_reg;
      end else if (timeout_evt) begin
         // Free-running wrap lands on the same value as its start
         count_next = periodic_select ? reload_value_reg : free_start;
      end else if (tick) begin
         count_next = count_up ? count_reg + 16'h0001 : count_reg - 16'h0001;
      end
   end

   // Edge detector resets low like a disabled timer, so no false start
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= `GPUT_CNT_ZERO;
         en_d_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         en_d_reg  <= tmr_en;
      end
   end

   // Timeout flag; a new timeout wins over a clear in the same cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         timeout_flag_reg <= 1'b0;
      end else if (timeout_evt) begin
         timeout_flag_reg <= 1'b1;
      end else if (clr_apply) begin
         timeout_flag_reg <= 1'b0;
      end
   end

   // Capture, held until capture-clear; an event with the clear wins
   // Count taken before this edge's update, as the event saw it
   assign cap_evt = ctrl_act_reg[`GPUT_CTL_CAP_EN]
                    & event_i[ctrl_act_reg[`GPUT_CTL_EVT_HI:`GPUT_CTL_EVT_LO]];

   always @(posedge clk_i) begin
      if (rst_i) begin
         capture_pending_reg <= 1'b0;
         captured_count_reg  <= `GPUT_RST_WORD;
      end else if (cap_evt && (!capture_pending_reg || clr_cap_wr)) begin
         capture_pending_reg <= 1'b1;
         captured_count_reg  <= count_reg;
      end else if (clr_cap_wr) begin
         capture_pending_reg <= 1'b0;
      end
   end

   // Count read path through a two-stage synchroniser
   // Only the second stage feeds the bus; the first is never read
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_meta_reg <= `GPUT_CNT_ZERO;
         cnt_sync_reg <= `GPUT_CNT_ZERO;
      end else begin
         cnt_meta_reg <= count_reg;
         cnt_sync_reg <= cnt_meta_reg;
      end
   end

endmodule // gput_timer

// [rtl/gput_map.vh]
// Register map, field positions, reset values and timing counts of the up/down timer
// Operation
// - Status bit 7 sets on timeout-clear write, self-clears once clear takes effect.
// - Status bit 6 reads one while a control write is still crossing over.
// - Status bit 1 reads one while a capture event is pending.
// - Status bit 0 sets at zero counting down or full scale counting up.
// - Timeout flag stays set until software writes one to timeout-clear.
// - Periodic mode reloads the counter from the load register every period.
// - Load write coinciding with a timeout is applied after the timeout passes.
// - Current-count register reads the count through a two-stage synchroniser.
// - With control bit 12 set, a selected event copies the count into capture.
// - Control bits 11 to 8 select one of sixteen event sources.
// - Periodic mode with control bit 7 set also resets count on timeout-clear.
// - Control bits 6 to 5 select the timer source clock.
// - Control bit 4 enables the timer; clearing it resets timer and count.
// - Control bit 3 selects periodic start from load or free-running start.
// - Control bit 2 selects direction: zero counts down, one counts up.
// - Control bits 1 to 0 select prescale 1 or 4, 16, 256 or 32768.
// - Capture register holds its value, ignoring events, until capture-clear.
// - Clear register bit 1 clears capture, bit 0 clears timeout; zero no effect.
`ifndef GPUT_MAP_VH
`define GPUT_MAP_VH

`define GPUT_ADR_T1_STATUS   32'h4000041c
`define GPUT_ADR_RELOAD      32'h40000800
`define GPUT_ADR_COUNT       32'h40000804
`define GPUT_ADR_CONTROL     32'h40000808
`define GPUT_ADR_CLEAR       32'h4000080c
`define GPUT_ADR_CAPTURE     32'h40000810
`define GPUT_ADR_STATUS      32'h4000081c

`define GPUT_RST_CONTROL     16'h000a
`define GPUT_RST_WORD        16'h0000

`define GPUT_CTL_CAP_EN      12
`define GPUT_CTL_EVT_HI      11
`define GPUT_CTL_EVT_LO      8
`define GPUT_CTL_RST_CLR     7
`define GPUT_CTL_SRC_HI      6
`define GPUT_CTL_SRC_LO      5
`define GPUT_CTL_ENABLE      4
`define GPUT_CTL_PERIODIC    3
`define GPUT_CTL_UP          2
`define GPUT_CTL_PRE_HI      1
`define GPUT_CTL_PRE_LO      0
`define GPUT_CTL_MASK        16'h1fff

`define GPUT_STA_CLR_PEND    7
`define GPUT_STA_BUSY        6
`define GPUT_STA_CAP         1
`define GPUT_STA_TIMEOUT_FLAG       0

`define GPUT_CLR_CAP         1
`define GPUT_CLR_TIMEOUT_FLAG       0

`define GPUT_SRC_PCLK        2'b00
`define GPUT_SRC_HCLK        2'b01
`define GPUT_SRC_LOW_FREQ_OSC       2'b10
`define GPUT_SRC_HFOSC       2'b11

`define GPUT_DIV_1           15'h0000
`define GPUT_DIV_4           15'h0003
`define GPUT_DIV_16          15'h000f
`define GPUT_DIV_256         15'h00ff
`define GPUT_DIV_32768       15'h7fff

// Three cycles so the next bus access still reads busy and clear pending
`define GPUT_XFER_CYC        2'd3
`define GPUT_CNT_ZERO        16'h0000
`define GPUT_CNT_FULL        16'hffff

`endif

// [test/gput_timer_assertions.sv]
// Port assertions for the up/down timer
`timescale 1ns/1ps
`include "gput_map.vh"

module gput_timer_chk (
   // Clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // Wishbone slave
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o
);
   logic [3:0] age_reg;
   logic       take;
   logic       rd;
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd   = take & ~wb_we_i;
   // Cycles since a control or clear write, saturating
   always @(posedge clk_i) begin
      if (rst_i || (take && wb_we_i && (wb_adr_i == `GPUT_ADR_CONTROL || wb_adr_i == `GPUT_ADR_CLEAR)))
         age_reg <= 4'h0;
      else if (age_reg != 4'hf)
         age_reg <= age_reg + 4'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence take_s; take; endsequence
   sequence read_s(logic [31:0] a); rd && wb_adr_i == a; endsequence
   // Busy and pending may only show within a few cycles of their cause
   sequence settled_s(logic [31:0] a); read_s(a) ##0 age_reg >= 4'h4; endsequence
   ack_latency_a: assert property (take_s |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0)
      else $error("bus active in reset");
   read_hold_a: assert property (!rd |=> $stable(wb_dat_o))
      else $error("read data moved without a read");
   upper_zero_a: assert property (rd |=> wb_dat_o[31:16] == 16'h0)
      else $error("upper read half not zero");
   ctl_reserved_a: assert property (read_s(`GPUT_ADR_CONTROL) |=> wb_dat_o[15:13] == 3'h0)
      else $error("control reserved bits set");
   sta_reserved_a: assert property (read_s(`GPUT_ADR_STATUS) |=> wb_dat_o[15:8] == 8'h0 && wb_dat_o[5:2] == 4'h0)
      else $error("status reserved bits set");
   busy_clear_a: assert property (settled_s(`GPUT_ADR_STATUS) |=> !wb_dat_o[6])
      else $error("busy stuck after transfer");
   pend_clear_a: assert property (settled_s(`GPUT_ADR_STATUS) |=> !wb_dat_o[7])
      else $error("clear pending stuck");
   t1_zero_a: assert property (read_s(`GPUT_ADR_T1_STATUS) |=> wb_dat_o == 32'h0)
      else $error("timer1 status not zero");
endmodule // gput_timer_chk

bind gput_timer gput_timer_chk u_gput_timer_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o);

// [test/gput_timer_test.sv]
// Self-checking bench for the up/down timer
`timescale 1ns/1ps
`include "gput_map.vh"

module gput_timer_test;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [31:0] adr   = 32'h0;
   logic [31:0] wdat  = 32'h0;
   logic [2:0]  tick  = 3'h0;
   logic [15:0] evt   = 16'h0;
   wire  [31:0] rdat;
   wire         ack;
   logic [15:0] rv;
   int          errors = 0;
   int          check_count = 0;

   always #2.5 clk_i = ~clk_i;

   gput_timer u_gput_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .hclk_tick_i(tick[0]), .low_freq_osc_tick_i(tick[1]), .hfosc_tick_i(tick[2]), .event_i(evt));

   task automatic results;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Iff sees ack as it stood before the edge, so no race
   task automatic wb(input logic w, input logic [31:0] a, input logic [15:0] d);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {16'h0, d};
      @(posedge clk_i iff ack === 1'b1);
      rv = rdat[15:0];
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [31:0] a, input logic [15:0] exp);
      wb(1'b0, a, 16'h0);
      chk(rv, exp);
   endtask

   // Busy must clear first, else the next write is dropped
   task automatic ctl(input logic [15:0] v);
      wb(1'b1, `GPUT_ADR_CONTROL, v);
      wb(1'b0, `GPUT_ADR_STATUS, 16'h0);
      chk({15'h0, rv[6]}, 16'h0001);
      while (rv[6] !== 1'b0)
         wb(1'b0, `GPUT_ADR_STATUS, 16'h0);
   endtask

   task automatic pulse(input logic [2:0] t, input logic [15:0] e);
      tick <= t;
      evt  <= e;
      @(posedge clk_i);
      tick <= 3'h0;
      evt  <= 16'h0;
      @(posedge clk_i);
   endtask

   task automatic t_reset;
      rchk(`GPUT_ADR_CONTROL, `GPUT_RST_CONTROL);
      rchk(`GPUT_ADR_RELOAD, 16'h0000);
      rchk(`GPUT_ADR_CAPTURE, 16'h0000);
      rchk(`GPUT_ADR_STATUS, 16'h0000);
      wb(1'b1, `GPUT_ADR_COUNT, 16'h1234);
      rchk(`GPUT_ADR_COUNT, 16'h0000);
      rchk(`GPUT_ADR_T1_STATUS, 16'h0000);
      rchk(32'h40000900, 16'h0000);
   endtask

   task automatic t_periodic;
      wb(1'b1, `GPUT_ADR_RELOAD, 16'h0040);
      rchk(`GPUT_ADR_RELOAD, 16'h0040);
      ctl(16'h0018);
      do
         wb(1'b0, `GPUT_ADR_STATUS, 16'h0);
      while (rv[0] !== 1'b1);
      wb(1'b0, `GPUT_ADR_COUNT, 16'h0);
      chk({15'h0, rv >= 16'h003a && rv <= 16'h0040}, 16'h0001);
      repeat (20) @(posedge clk_i);
      wb(1'b1, `GPUT_ADR_CLEAR, 16'h0000);
      rchk(`GPUT_ADR_STATUS, 16'h0001);
      wb(1'b1, `GPUT_ADR_CLEAR, 16'h0001);
      rchk(`GPUT_ADR_STATUS, 16'h0081);
      rchk(`GPUT_ADR_STATUS, 16'h0000);
      // Reset-on-clear pulls the count back to the load value
      ctl(16'h0098);
      repeat (40) @(posedge clk_i);
      wb(1'b1, `GPUT_ADR_CLEAR, 16'h0001);
      repeat (4) @(posedge clk_i);
      wb(1'b0, `GPUT_ADR_COUNT, 16'h0);
      chk({15'h0, rv >= 16'h003e && rv <= 16'h0040}, 16'h0001);
   endtask

   task automatic t_free;
      logic [15:0] c1;
      ctl(16'h0000);
      rchk(`GPUT_ADR_COUNT, 16'h0000);
      ctl(16'h0014);
      wb(1'b0, `GPUT_ADR_COUNT, 16'h0);
      c1 = rv;
      chk({15'h0, c1 < 16'h0008}, 16'h0001);
      repeat (40) @(posedge clk_i);
      wb(1'b0, `GPUT_ADR_COUNT, 16'h0);
      chk({15'h0, rv - c1 >= 16'h0009 && rv - c1 <= 16'h000c}, 16'h0001);
      pulse(3'h0, 16'hffff);
      rchk(`GPUT_ADR_STATUS, 16'h0000);
   endtask

   task automatic t_capture;
      logic [15:0] cap;
      for (int i = 0; i < 16; i++) begin
         ctl({3'h0, 1'b1, i[3:0], 8'h14});
         pulse(3'h0, ~(16'h0001 << i));
         rchk(`GPUT_ADR_STATUS, 16'h0000);
         pulse(3'h0, 16'h0001 << i);
         rchk(`GPUT_ADR_STATUS, 16'h0002);
         wb(1'b1, `GPUT_ADR_CLEAR, 16'h0002);
         rchk(`GPUT_ADR_STATUS, 16'h0000);
      end
      pulse(3'h0, 16'h8000);
      wb(1'b0, `GPUT_ADR_CAPTURE, 16'h0);
      cap = rv;
      repeat (16) @(posedge clk_i);
      pulse(3'h0, 16'h8000);
      rchk(`GPUT_ADR_CAPTURE, cap);
      wb(1'b1, `GPUT_ADR_CLEAR, 16'h0002);
      pulse(3'h0, 16'h8000);
      wb(1'b0, `GPUT_ADR_CAPTURE, 16'h0);
      chk({15'h0, rv != cap}, 16'h0001);
   endtask

   // Outside sources count only on their own ticks; free run down
   task automatic t_source;
      for (int s = 1; s < 4; s++) begin
         ctl(16'h0000);
         ctl({9'h0, s[1:0], 5'h10});
         repeat (8) pulse(3'(1 << (s - 1)), 16'h0);
         // Count reads lag two cycles behind the last tick
         repeat (2) @(posedge clk_i);
         rchk(`GPUT_ADR_COUNT, (s == 1) ? 16'hfffd : 16'hfff7);
      end
      for (int p = 1; p < 3; p++) begin
         ctl(16'h0000);
         ctl(16'h0050 + p[15:0]);
         repeat ((p == 1) ? 32 : 512) pulse(3'h2, 16'h0);
         repeat (2) @(posedge clk_i);
         rchk(`GPUT_ADR_COUNT, 16'hfffd);
      end
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_periodic();
      t_free();
      t_capture();
      t_source();
      results();
   end

   // Whole run needs well under this
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      results();
   end
endmodule // gput_timer_test
